// ---- common/plc_pkg.sv ----
// package of register offsets and reset values for the parallel line controller
package plc_pkg;
    localparam int unsigned PLC_DATA_W = 32;
    localparam int unsigned PLC_ADDR_W = 8;
    // byte offsets, one aligned word per register
    localparam logic [7:0] PLC_OWN_EN = 8'h00;
    localparam logic [7:0] PLC_OWN_DIS = 8'h04;
    localparam logic [7:0] PLC_OWN_STAT = 8'h08;
    localparam logic [7:0] PLC_DRV_EN = 8'h10;
    localparam logic [7:0] PLC_DRV_DIS = 8'h14;
    localparam logic [7:0] PLC_DRV_STAT = 8'h18;
    localparam logic [7:0] PLC_FLT_EN = 8'h20;
    localparam logic [7:0] PLC_FLT_DIS = 8'h24;
    localparam logic [7:0] PLC_FLT_STAT = 8'h28;
    localparam logic [7:0] PLC_LAT_SET = 8'h30;
    localparam logic [7:0] PLC_LAT_CLR = 8'h34;
    localparam logic [7:0] PLC_LAT_STAT = 8'h38;
    localparam logic [7:0] PLC_LVL_STAT = 8'h3c;
    localparam logic [7:0] PLC_IRQ_EN = 8'h40;
    localparam logic [7:0] PLC_IRQ_DIS = 8'h44;
    localparam logic [7:0] PLC_IRQ_MASK = 8'h48;
    localparam logic [7:0] PLC_CHG_STAT = 8'h4c;
    localparam logic [7:0] PLC_OD_EN = 8'h50;
    localparam logic [7:0] PLC_OD_DIS = 8'h54;
    localparam logic [7:0] PLC_OD_STAT = 8'h58;
    // reset values of the control bits
    localparam logic [31:0] PLC_OWN_RST = 32'hffffffff;
    localparam logic [31:0] PLC_ZERO = 32'h00000000;
    localparam logic [31:0] PLC_UNMAPPED = 32'h00000000;
    typedef enum logic [1:0] {
        PLC_S_IDLE = 2'b00,
        PLC_S_ACK = 2'b01
    } plc_bus_e;
endpackage

// ---- tb/plc_pad_model.sv ----
// pad model: resolves every line from the device drive and a weak external level
`timescale 1ns/1ps
module plc_pad_model (
    input wire logic [31:0] pin_out_i, // device pad value
    input wire logic [31:0] pin_oe_b_i, // device pad enable, low drives
    input wire logic [31:0] ext_lvl_i, // weak external level through a resistor
    output logic [31:0] pin_lvl_o // resolved pad level
);
    // an undriven line follows the external pull, so a released open-drain line takes the ext_lvl_i level
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin_lvl_o[i] = pin_oe_b_i[i] ? ext_lvl_i[i] : pin_out_i[i];
        end
    end
endmodule

// ---- tb/tb_plc_line_controller.sv ----
// self-checking bench for the parallel line controller
`timescale 1ns/1ps
module tb_plc_line_controller;
    import plc_pkg::*;
    localparam logic [31:0] P = 32'h07ffffff;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] be = 4'hf;
    logic [31:0] wd = '0, pin_ext = '0, p_out = '0, p_oe = '0;
    logic [31:0] rdat, pout, poe_b, pin, p_in, own, drv, flt, lat, msk, od, t, r;
    logic wrq, irq;
    logic [7:0] ops [14] = '{PLC_OWN_EN, PLC_OWN_DIS, PLC_DRV_EN, PLC_DRV_DIS, PLC_FLT_EN, PLC_FLT_DIS,
        PLC_LAT_SET, PLC_LAT_CLR, PLC_IRQ_EN, PLC_IRQ_DIS, PLC_OD_EN, PLC_OD_DIS, PLC_OWN_STAT, 8'h0c};
    logic [7:0] sa [8] = '{PLC_OWN_STAT, PLC_DRV_STAT, PLC_FLT_STAT, PLC_LAT_STAT, PLC_LVL_STAT,
        PLC_IRQ_MASK, PLC_OD_STAT, 8'h0c};
    int miscompares = 0;
    int cmp_count = 0;
    always #12.5 core_clk_i = ~core_clk_i;
    plc_line_controller #(.NUM_LINES(27)) plc_line_controller_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .pin_in_i(pin), .pin_out_o(pout), .pin_oe_b_o(poe_b),
        .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(p_in), .irq_o(irq));
    plc_pad_model plc_pad_model_i (.pin_out_i(pout), .pin_oe_b_i(poe_b), .ext_lvl_i(pin_ext), .pin_lvl_o(pin));
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one access; the request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk_i);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        do @(posedge core_clk_i); while (wrq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] m;
        bus(1'b1, a, d, r);
        m = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & P;
        case (a)
            PLC_OWN_EN: own |= m;
            PLC_OWN_DIS: own &= ~m;
            PLC_DRV_EN: drv |= m;
            PLC_DRV_DIS: drv &= ~m;
            PLC_FLT_EN: flt |= m;
            PLC_FLT_DIS: flt &= ~m;
            PLC_LAT_SET: lat |= m;
            PLC_LAT_CLR: lat &= ~m;
            PLC_IRQ_EN: msk |= m;
            PLC_IRQ_DIS: msk &= ~m;
            PLC_OD_EN: od |= m;
            PLC_OD_DIS: od &= ~m;
            default: ;
        endcase
    endtask
    task automatic check_all();
        logic [31:0] v, d, lv;
        logic [31:0] se [8];
        repeat (6) @(posedge core_clk_i);
        v = (own & lat) | (~own & p_out);
        d = P & ((own & drv) | (~own & p_oe)) & (~od | ~v);
        lv = (d & v) | (~d & pin_ext);
        chk("pad enable", ~d, poe_b);
        chk("pad value", d & v, pout & d);
        chk("periph in", P & ~own & lv, p_in & P);
        se = '{own, drv, flt, lat, lv & P, msk, od, 32'h0};
        foreach (sa[i]) begin
            bus(1'b0, sa[i], 32'h0, r);
            chk($sformatf("reg %h", sa[i]), se[i], r);
        end
    endtask
    initial begin
        repeat (50000) @(posedge core_clk_i);
        miscompares++;
        final_report();
    end
    initial begin
        own = P;
        {drv, flt, lat, msk, od} = '0;
        t = $urandom(32'hd424);
        pin_ext <= $urandom();
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        check_all();
        bus(1'b0, PLC_CHG_STAT, 32'h0, r);
        chk("change after reset", 32'h0, r);
        for (int n = 0; n < 200; n++) begin
            @(posedge core_clk_i);
            be <= (n % 4 == 0) ? 4'($urandom()) : 4'hf;
            p_out <= $urandom();
            p_oe <= $urandom();
            wreg(ops[$urandom_range(13)], $urandom());
            if (n % 8 == 7) check_all();
        end
        be <= 4'hf;
        wreg(PLC_OWN_EN, 32'hffffffff);
        wreg(PLC_DRV_DIS, 32'hffffffff);
        wreg(PLC_FLT_DIS, 32'hffffffff);
        for (int k = 0; k < 5; k++) begin
            wreg(PLC_IRQ_DIS, 32'hffffffff);
            wreg(PLC_IRQ_EN, (k == 0) ? 32'h0 : $urandom());
            bus(1'b0, PLC_CHG_STAT, 32'h0, r);
            t = $urandom();
            pin_ext <= pin_ext ^ t;
            repeat (6) @(posedge core_clk_i);
            chk("irq", {31'h0, |(t & msk & P)}, {31'h0, irq});
            bus(1'b0, PLC_CHG_STAT, 32'h0, r);
            chk("change", t & P, r);
            bus(1'b0, PLC_CHG_STAT, 32'h0, r);
            chk("change cleared", 32'h0, r);
        end
        for (int f = 0; f < 2; f++) begin
            wreg((f == 0) ? PLC_FLT_EN : PLC_FLT_DIS, 32'h1);
            repeat (4) @(posedge core_clk_i);
            bus(1'b0, PLC_CHG_STAT, 32'h0, r);
            @(posedge core_clk_i);
            pin_ext[0] <= ~pin_ext[0];
            @(posedge core_clk_i);
            pin_ext[0] <= ~pin_ext[0];
            repeat (6) @(posedge core_clk_i);
            bus(1'b0, PLC_CHG_STAT, 32'h0, r);
            chk("glitch", (f == 1) ? 32'h1 : 32'h0, r & 32'h1);
        end
        final_report();
    end
endmodule

// ---- verilog/plc_line_controller.sv ----
// parallel line controller: per-pin ownership, direction, latch, filter, open drain, change detect
// Overview of operation
// - 54 bidirectional lines over two identical instances, each line muxed with a peripheral
// - each instance drives one interrupt output toward the interrupt controller
// - ownership-enable write of one hands pin to controller, zero no effect
// - ownership-disable write of one returns pin to peripheral, zero no effect
// - ownership status reads one for controller-owned pins, updated by both writes
// - peripheral input from a controller-owned pin is forced to zero
// - direction bits always stored, steer driver only when controller owns pin
// - direction status reads one for outputs, zero for inputs
// - set/clear data writes change latch; latch drives only when owned and output
// - output latch status returns the current latch value
// - owned pin not configured as output is not driven
// - pin level register returns the sampled pin level, filtered on lines whose filter is on
// - filter enable/disable switch per-pin glitch filter, status reads one where active
// - irq enable/disable set or clear mask bits, mask readable
// - any level change sets change bit regardless of ownership, direction, mask
// - interrupt asserted when any pin has change bit and mask bit set
// - reading change status returns contents then clears all bits; reset clears it
// - registers 32 bits, one bit per line, absent lines ignore writes read zero
// - open-drain pins drive only low, release for high, under either owner
// - multi-drive enable/disable set or clear open-drain bits, status readable
// - pin level register resets to zero, then loads the pin levels on the first edge after reset release
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module plc_line_controller
    import plc_pkg::*;
#(
    parameter int unsigned NUM_LINES = 32 // lines present in this instance
) (
    input wire logic core_clk_i, // system clock, 40 MHz
    input wire logic rst_b_i, // asynchronous reset, active low
    input wire logic [plc_pkg::PLC_ADDR_W-1:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [plc_pkg::PLC_DATA_W-1:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes of a write
    output logic [plc_pkg::PLC_DATA_W-1:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // high until the access is answered
    input wire logic [31:0] pin_in_i, // pad input levels
    output logic [31:0] pin_out_o, // pad output value
    output logic [31:0] pin_oe_b_o, // pad output enable, low drives
    input wire logic [31:0] periph_out_i, // peripheral output per line
    input wire logic [31:0] periph_oe_i, // peripheral output enable per line, high drives
    output logic [31:0] periph_in_o, // filtered pin level to the peripheral
    output logic irq_o // level interrupt to the system interrupt controller
);
    import plc_pkg::*;

    initial begin
        if (NUM_LINES < 1 || NUM_LINES > PLC_DATA_W) begin
            $error("NUM_LINES must be 1 to 32");
        end
    end

    localparam logic [31:0] LINE_MASK = 32'({{(PLC_DATA_W-1){1'b0}}, 1'b1} << NUM_LINES) - 32'h1 |
        ((NUM_LINES == PLC_DATA_W) ? 32'hffffffff : 32'h0);

    logic [31:0] own_reg;
    logic [31:0] drv_reg;
    logic [31:0] flt_reg;
    logic [31:0] lat_reg;
    logic [31:0] msk_reg;
    logic [31:0] od_reg;
    logic [31:0] chg_reg;
    logic [31:0] raw_reg;
    logic [31:0] raw2_reg;
    logic [31:0] lvl_reg;
    logic [31:0] lvl_next;
    logic [31:0] prev_reg;
    logic lvl_valid_reg;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [31:0] rd_next;
    logic wr_go;
    logic rd_go;
    logic chg_rd;
    plc_bus_e bus_reg;

    // byte lanes gate the write bits, absent lines never change
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
        end
        wdat = avs_writedata_i & wmask & LINE_MASK;
    end

    // one wait cycle per access: answered on the second edge
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_reg <= PLC_S_IDLE;
        end else begin
            case (bus_reg)
                PLC_S_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_reg <= PLC_S_ACK;
                    end
                end
                PLC_S_ACK: bus_reg <= PLC_S_IDLE;
                default: bus_reg <= PLC_S_IDLE;
            endcase
        end
    end

    assign wr_go = (bus_reg == PLC_S_IDLE) && avs_write_i;
    assign rd_go = (bus_reg == PLC_S_IDLE) && avs_read_i;
    assign chg_rd = rd_go && (avs_address_i == PLC_CHG_STAT);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && bus_reg == PLC_S_IDLE);
        end
    end

    // set/clear pairs; a one sets or clears, a zero leaves the bit
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            own_reg <= PLC_OWN_RST & LINE_MASK;
        end else if (wr_go && avs_address_i == PLC_OWN_EN) begin
            own_reg <= own_reg | wdat;
        end else if (wr_go && avs_address_i == PLC_OWN_DIS) begin
            own_reg <= own_reg & ~wdat;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drv_reg <= PLC_ZERO;
        end else if (wr_go && avs_address_i == PLC_DRV_EN) begin
            drv_reg <= drv_reg | wdat;
        end else if (wr_go && avs_address_i == PLC_DRV_DIS) begin
            drv_reg <= drv_reg & ~wdat;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flt_reg <= PLC_ZERO;
        end else if (wr_go && avs_address_i == PLC_FLT_EN) begin
            flt_reg <= flt_reg | wdat;
        end else if (wr_go && avs_address_i == PLC_FLT_DIS) begin
            flt_reg <= flt_reg & ~wdat;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lat_reg <= PLC_ZERO;
        end else if (wr_go && avs_address_i == PLC_LAT_SET) begin
            lat_reg <= lat_reg | wdat;
        end else if (wr_go && avs_address_i == PLC_LAT_CLR) begin
            lat_reg <= lat_reg & ~wdat;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            msk_reg <= PLC_ZERO;
        end else if (wr_go && avs_address_i == PLC_IRQ_EN) begin
            msk_reg <= msk_reg | wdat;
        end else if (wr_go && avs_address_i == PLC_IRQ_DIS) begin
            msk_reg <= msk_reg & ~wdat;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            od_reg <= PLC_ZERO;
        end else if (wr_go && avs_address_i == PLC_OD_EN) begin
            od_reg <= od_reg | wdat;
        end else if (wr_go && avs_address_i == PLC_OD_DIS) begin
            od_reg <= od_reg & ~wdat;
        end
    end

    // two-stage input sampling; filter passes a level only once it held two samples
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            raw_reg <= PLC_ZERO;
            raw2_reg <= PLC_ZERO;
        end else begin
            raw_reg <= pin_in_i & LINE_MASK;
            raw2_reg <= raw_reg;
        end
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            // a one-cycle glitch never matches both samples
            if (flt_reg[i] && (raw_reg[i] != raw2_reg[i])) begin
                lvl_next[i] = lvl_reg[i];
            end else begin
                lvl_next[i] = raw_reg[i];
            end
        end
    end

    // level register is loaded from the pins right after reset release
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lvl_reg <= PLC_ZERO;
            prev_reg <= PLC_ZERO;
            lvl_valid_reg <= 1'b0;
        end else begin
            lvl_valid_reg <= 1'b1;
            lvl_reg <= lvl_valid_reg ? lvl_next : (pin_in_i & LINE_MASK);
            // first load seeds the previous level too, so reset release is no false change
            prev_reg <= lvl_valid_reg ? lvl_reg : (pin_in_i & LINE_MASK);
        end
    end

    // change bits: new event wins over the clearing read
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chg_reg <= PLC_ZERO;
        end else begin
            chg_reg <= (chg_rd ? PLC_ZERO : chg_reg) | (lvl_valid_reg ? (lvl_reg ^ prev_reg) : PLC_ZERO);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(chg_reg & msk_reg);
        end
    end

    // pad drive: owner picks source; open drain only ever drives low
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_out_o <= PLC_ZERO;
            pin_oe_b_o <= 32'hffffffff;
            periph_in_o <= PLC_ZERO;
        end else begin
            for (int i = 0; i < 32; i++) begin
                logic val;
                logic en;
                val = own_reg[i] ? lat_reg[i] : periph_out_i[i];
                en = own_reg[i] ? drv_reg[i] : periph_oe_i[i];
                if (od_reg[i]) begin
                    en = en & ~val;
                end
                pin_out_o[i] <= val & LINE_MASK[i];
                pin_oe_b_o[i] <= ~(en & LINE_MASK[i]);
                periph_in_o[i] <= own_reg[i] ? 1'b0 : lvl_next[i];
            end
        end
    end

    always_comb begin
        case (avs_address_i)
            PLC_OWN_STAT: rd_next = own_reg;
            PLC_DRV_STAT: rd_next = drv_reg;
            PLC_FLT_STAT: rd_next = flt_reg;
            PLC_LAT_STAT: rd_next = lat_reg;
            PLC_LVL_STAT: rd_next = lvl_reg;
            PLC_IRQ_MASK: rd_next = msk_reg;
            PLC_CHG_STAT: rd_next = chg_reg;
            PLC_OD_STAT: rd_next = od_reg;
            default: rd_next = PLC_UNMAPPED;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= PLC_ZERO;
        end else if (rd_go) begin
            avs_readdata_o <= rd_next & LINE_MASK;
        end
    end

    a_own_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OWN_EN |=> ((own_reg & $past(wdat)) == $past(wdat)))
        else $error("ownership enable did not take");
    a_own_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OWN_DIS |=> ((own_reg & $past(wdat)) == PLC_ZERO))
        else $error("ownership disable did not take");
    a_periph_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 (($past(own_reg) & periph_in_o) == PLC_ZERO))
        else $error("peripheral input not forced low");
    a_hiz_input: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 ((($past(own_reg) & ~$past(drv_reg)) & ~pin_oe_b_o) == PLC_ZERO))
        else $error("owned input pin driven");
    a_od_low_only: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 ((~pin_oe_b_o & pin_out_o & $past(od_reg)) == PLC_ZERO))
        else $error("open drain pin driven high");
    a_irq_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        |(chg_reg & msk_reg) |=> irq_o)
        else $error("interrupt missing");
    a_chg_sets: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        lvl_valid_reg && (lvl_reg != prev_reg) |=> ((chg_reg & $past(lvl_reg ^ prev_reg)) != PLC_ZERO))
        else $error("level change lost");
    a_chg_rdclr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        chg_rd && !(lvl_valid_reg && lvl_reg != prev_reg) |=> chg_reg == PLC_ZERO)
        else $error("change status not cleared by read");
    a_absent_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (avs_readdata_o & ~LINE_MASK) == PLC_ZERO)
        else $error("absent line bit reads one");
    a_bus_answer: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        bus_reg == PLC_S_IDLE && (avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("bus access not answered");
    a_wait_one: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_own_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OWN_EN |=> ((own_reg & ~$past(wdat)) == ($past(own_reg) & ~$past(wdat))))
        else $error("ownership enable disturbed zero bits");
    a_own_dis_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OWN_DIS |=> ((own_reg | $past(wdat)) == ($past(own_reg) | $past(wdat))))
        else $error("ownership disable disturbed zero bits");
    a_drv_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_DRV_EN |=> ((drv_reg & $past(wdat)) == $past(wdat)))
        else $error("output enable did not take");
    a_drv_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_DRV_DIS |=> ((drv_reg & $past(wdat)) == PLC_ZERO))
        else $error("output disable did not take");
    a_flt_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_FLT_EN |=> ((flt_reg & $past(wdat)) == $past(wdat)))
        else $error("filter enable did not take");
    a_flt_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_FLT_DIS |=> ((flt_reg & $past(wdat)) == PLC_ZERO))
        else $error("filter disable did not take");
    a_lat_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_LAT_SET |=> ((lat_reg & $past(wdat)) == $past(wdat)))
        else $error("latch set did not take");
    a_lat_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_LAT_CLR |=> ((lat_reg & $past(wdat)) == PLC_ZERO))
        else $error("latch clear did not take");
    a_msk_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_IRQ_EN |=> ((msk_reg & $past(wdat)) == $past(wdat)))
        else $error("interrupt enable did not take");
    a_msk_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_IRQ_DIS |=> ((msk_reg & $past(wdat)) == PLC_ZERO))
        else $error("interrupt disable did not take");
    a_od_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OD_EN |=> ((od_reg & $past(wdat)) == $past(wdat)))
        else $error("open drain enable did not take");
    a_od_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OD_DIS |=> ((od_reg & $past(wdat)) == PLC_ZERO))
        else $error("open drain disable did not take");
    a_absent_own: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (own_reg & ~LINE_MASK) == PLC_ZERO)
        else $error("absent line owned");
    a_absent_pad: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (~pin_oe_b_o & ~LINE_MASK) == PLC_ZERO)
        else $error("absent line driven");
    a_rd_own: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go && avs_address_i == PLC_OWN_STAT |=> avs_readdata_o == $past(own_reg))
        else $error("ownership status read wrong");
    a_rd_drv: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go && avs_address_i == PLC_DRV_STAT |=> avs_readdata_o == $past(drv_reg))
        else $error("direction status read wrong");
    a_rd_lat: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go && avs_address_i == PLC_LAT_STAT |=> avs_readdata_o == $past(lat_reg))
        else $error("latch status read wrong");
    a_rd_lvl: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go && avs_address_i == PLC_LVL_STAT |=> avs_readdata_o == $past(lvl_reg))
        else $error("pin level read wrong");
    a_rd_msk: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_go && avs_address_i == PLC_IRQ_MASK |=> avs_readdata_o == $past(msk_reg))
        else $error("mask read wrong");
    a_irq_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !(|(chg_reg & msk_reg)) |=> !irq_o)
        else $error("interrupt without cause");
    a_owned_drive: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 (($past(own_reg) & $past(drv_reg) & ~$past(od_reg) & pin_oe_b_o) == PLC_ZERO))
        else $error("owned output pin not driven");
    a_owned_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 ((~pin_oe_b_o & $past(own_reg) & (pin_out_o ^ $past(lat_reg))) == PLC_ZERO))
        else $error("owned pin drives other than latch");

    c_own_write: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_go && avs_address_i == PLC_OWN_EN);
    c_irq_fire: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) $rose(irq_o));
    c_chg_read: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) chg_rd && chg_reg != PLC_ZERO);
    c_od_drive: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) |(od_reg & ~pin_oe_b_o));
endmodule
